// [hdl/dts_cfg.svh]
// constants for the training fifo sequencer: sizes, offsets, fields, reset values
`ifndef DTS_CFG_SVH
`define DTS_CFG_SVH

// ----------------------------------------------------------------
// fifo and burst geometry
// ----------------------------------------------------------------
`define DTS_FIFO_DEPTH 3'h5
`define DTS_PTR_LAST 3'h4
`define DTS_BEATS 16
`define DTS_DQ 8
`define DTS_BURST_W 128
`define DTS_PIPE_D 32
`define DTS_TAP_W 5
`define DTS_LAT_MIN 6'h02
`define DTS_LAT_MAX 6'h21
`define DTS_LAT_RST 6'h0E
`define DTS_GAP_RST 8'h18

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define DTS_OFS_CTRL 8'h00
`define DTS_OFS_PAT 8'h04
`define DTS_OFS_STAT 8'h08
`define DTS_OFS_GAP 8'h0C
`define DTS_CTRL_LAT 5:0
`define DTS_CTRL_DM 8
`define DTS_CTRL_WDBI 9
`define DTS_CTRL_RDBI 10
`define DTS_PAT_F 15:0
`define DTS_GAP_F 7:0
`define DTS_STAT_WRPTR 2:0
`define DTS_STAT_RDPTR 6:4
`define DTS_STAT_FILL 10:8
`define DTS_STAT_ERR 18:16

`endif

// [hdl/dts_pkg.sv]
// types of the training fifo sequencer
package dts_pkg;
    typedef enum logic [3:0] {CMD_NONE, CMD_WR, CMD_MWR, CMD_RD, CMD_MRR, CMD_MRW, CMD_CAS2,
        CMD_WRFIFO, CMD_RDFIFO, CMD_RDCAL, CMD_OTHER} dts_cmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WRF, ST_RDF, ST_CAL} dts_mpc_t;
    typedef struct packed {
        logic valid;
        logic isCal;
        logic undef;
        logic [2:0] idx;
    } dts_slot_t;
endpackage

// [hdl/dts_reg_if.sv]
// register fields passed between the bus slave and the sequencer core
`timescale 1ns/1ps
interface dts_reg_if;
    logic [5:0] readLat;
    logic dmEn;
    logic wdbiEn;
    logic rdbiEn;
    logic [15:0] pattern;
    logic [7:0] gap;
    logic [31:0] status;
    logic [2:0] errClr;
    modport regs (output readLat, dmEn, wdbiEn, rdbiEn, pattern, gap, errClr, input status);
    modport core (input readLat, dmEn, wdbiEn, rdbiEn, pattern, gap, errClr, output status);
endinterface

// [hdl/dts_lat_pipe.sv]
// delay line with a selectable tap, used for the read latency
`timescale 1ns/1ps
`include "dts_cfg.svh"
module dts_lat_pipe #(
    parameter int W = 6,
    parameter int D = 32
) (
    input logic clk,
    input logic rstN,
    input logic [W-1:0] inData,
    input logic [`DTS_TAP_W-1:0] tapSel,
    output logic [W-1:0] tapData
);
    logic [W-1:0] stage [0:D-1];

    // shift one stage per clock
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < D; i++) begin
                stage[i] <= '0;
            end
        end else begin
            stage[0] <= inData;
            for (int i = 1; i < D; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    // tap k is seen k+1 cycles after the input
    assign tapData = stage[tapSel];
endmodule

// [hdl/dts_ahb_regs.sv]
// ahb-lite slave holding the sequencer control registers
`timescale 1ns/1ps
`include "dts_cfg.svh"
module dts_ahb_regs (
    input logic clk,
    input logic rstN,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    dts_reg_if.regs rif
);
    logic addrPhase;
    logic wrPend;
    logic [7:0] wrAddr;

    // only word transfers are issued; hsize is not decoded
    assign addrPhase = hsel && hready && htrans[1];

    // capture the write address phase
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // register writes at the end of the data phase
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rif.readLat <= `DTS_LAT_RST;
            rif.dmEn <= 1'b0;
            rif.wdbiEn <= 1'b0;
            rif.rdbiEn <= 1'b0;
            rif.pattern <= 16'h0000;
            rif.gap <= `DTS_GAP_RST;
        end else if (wrPend) begin
            if (wrAddr == `DTS_OFS_CTRL) begin
                rif.readLat <= hwdata[`DTS_CTRL_LAT];
                rif.dmEn <= hwdata[`DTS_CTRL_DM];
                rif.wdbiEn <= hwdata[`DTS_CTRL_WDBI];
                rif.rdbiEn <= hwdata[`DTS_CTRL_RDBI];
            end
            if (wrAddr == `DTS_OFS_PAT) begin
                rif.pattern <= hwdata[`DTS_PAT_F];
            end
            if (wrAddr == `DTS_OFS_GAP) begin
                rif.gap <= hwdata[`DTS_GAP_F];
            end
        end
    end

    // write-one-to-clear pulse for the sticky error bits
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rif.errClr <= 3'h0;
        end else begin
            rif.errClr <= (wrPend && wrAddr == `DTS_OFS_STAT) ? hwdata[`DTS_STAT_ERR] : 3'h0;
        end
    end

    // read data registered at the address phase, zero wait states
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            if (addrPhase && !hwrite) begin
                case (haddr[7:0])
                    `DTS_OFS_CTRL: hrdata <= {21'h000000, rif.rdbiEn, rif.wdbiEn, rif.dmEn, 2'h0, rif.readLat};
                    `DTS_OFS_PAT: hrdata <= {16'h0000, rif.pattern};
                    `DTS_OFS_STAT: hrdata <= rif.status;
                    `DTS_OFS_GAP: hrdata <= {24'h000000, rif.gap};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// [hdl/dts_top.sv]
// training fifo sequencer: command decode, five-entry fifo, read latency path
//
// Behaviour
// - write-fifo accepted in any bank state
// - same training commands run back to back
// - read-fifo data uses normal read latency
// - read pointer advances, wraps after five
// - unwritten entries return undefined data
// - dmi driven when dbi or mask enabled
// - sixth write-fifo overwrites the first entry
// - pointers reset by cke low, other accesses
`timescale 1ns/1ps
`include "dts_cfg.svh"
module dts_top (
    input logic clk_sys,
    input logic rst_n,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input logic [3:0] cmdOp,
    input logic [5:0] casOperand,
    input logic cke,
    input logic [`DTS_BURST_W-1:0] wrBurst,
    input logic wrBurstValid,
    output logic [`DTS_BURST_W-1:0] rdBurst,
    output logic rdBurstValid,
    output logic dmiDrive,
    output logic rdUndef
);
    // ------------------------------------------------------------
    // reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rstPipe;
    logic rstN;
    logic ckeMeta;
    logic ckeS;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // clock enable pin through two flops
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ckeMeta <= 1'b0;
            ckeS <= 1'b0;
        end else begin
            ckeMeta <= cke;
            ckeS <= ckeMeta;
        end
    end

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    dts_reg_if rif ();

    dts_ahb_regs u_regs (
        .clk(clk_sys),
        .rstN(rstN),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rif(rif)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    dts_pkg::dts_cmd_t cmd;
    dts_pkg::dts_mpc_t st;
    dts_pkg::dts_mpc_t next_st;
    logic casHit;
    logic execWr;
    logic execRd;
    logic execCal;
    logic disturb;
    logic wrTake;

    // commands count only while the clock enable is high, in any bank or refresh state
    assign cmd = ckeS ? dts_pkg::dts_cmd_t'(cmdOp) : dts_pkg::CMD_NONE;

    // remember which training command waits for its cas-2
    always_comb begin
        case (cmd)
            dts_pkg::CMD_WRFIFO: next_st = dts_pkg::ST_WRF;
            dts_pkg::CMD_RDFIFO: next_st = dts_pkg::ST_RDF;
            dts_pkg::CMD_RDCAL: next_st = dts_pkg::ST_CAL;
            default: next_st = dts_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            st <= dts_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // execution and latency start at the cas-2 cycle
    assign casHit = (st != dts_pkg::ST_IDLE) && (cmd == dts_pkg::CMD_CAS2);
    assign execWr = casHit && (st == dts_pkg::ST_WRF);
    assign execRd = casHit && (st == dts_pkg::ST_RDF);
    assign execCal = casHit && (st == dts_pkg::ST_CAL);

    // these accesses or a low clock enable reset the fifo pointers to zero
    assign disturb = !ckeS || execCal || cmd == dts_pkg::CMD_WR || cmd == dts_pkg::CMD_MWR
        || cmd == dts_pkg::CMD_RD || cmd == dts_pkg::CMD_MRR;

    // ------------------------------------------------------------
    // training fifo and pointers
    // ------------------------------------------------------------
    logic [`DTS_BURST_W-1:0] fifoMem [0:4];
    logic [2:0] wrPtr;
    logic [2:0] rdPtr;
    logic [2:0] fill;
    logic [2:0] wrArm;

    // a burst is stored only when a write-fifo command asked for it
    assign wrTake = wrBurstValid && (wrArm != 3'h0) && !disturb;

    // outstanding write-fifo bursts, one per executed command
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wrArm <= 3'h0;
        end else if (disturb) begin
            wrArm <= 3'h0;
        end else if (execWr && !wrTake && wrArm != `DTS_FIFO_DEPTH) begin
            wrArm <= wrArm + 3'h1;
        end else if (wrTake && !execWr) begin
            wrArm <= wrArm - 3'h1;
        end
    end

    // write pointer wraps, so a sixth burst lands on the first entry
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wrPtr <= 3'h0;
            fill <= 3'h0;
        end else if (disturb) begin
            wrPtr <= 3'h0;
            fill <= 3'h0;
        end else if (wrTake) begin
            wrPtr <= (wrPtr == `DTS_PTR_LAST) ? 3'h0 : wrPtr + 3'h1;
            fill <= (fill == `DTS_FIFO_DEPTH) ? fill : fill + 3'h1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_sys) begin
        if (wrTake) begin
            fifoMem[wrPtr] <= wrBurst;
        end
    end

    // read pointer advances on each read-fifo and wraps after five
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdPtr <= 3'h0;
        end else if (disturb) begin
            rdPtr <= 3'h0;
        end else if (execRd) begin
            rdPtr <= (rdPtr == `DTS_PTR_LAST) ? 3'h0 : rdPtr + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // controller protocol monitors
    // ------------------------------------------------------------
    logic [7:0] gapCnt;
    logic [2:0] errs;
    logic [2:0] errSet;

    // counts down the read gap after each read-fifo
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            gapCnt <= 8'h00;
        end else if (execRd) begin
            gapCnt <= rif.gap;
        end else if (gapCnt != 8'h00) begin
            gapCnt <= gapCnt - 8'h01;
        end
    end

    // bit 0 operands, bit 1 missing cas-2, bit 2 read too early
    assign errSet = {cmd == dts_pkg::CMD_RD && gapCnt != 8'h00,
        st != dts_pkg::ST_IDLE && cmd != dts_pkg::CMD_CAS2,
        casHit && casOperand != 6'h00};

    // sticky errors; a new event wins over a clear
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            errs <= 3'h0;
        end else begin
            errs <= (errs & ~rif.errClr) | errSet;
        end
    end

    // status word
    always_comb begin
        rif.status = 32'h00000000;
        rif.status[`DTS_STAT_WRPTR] = wrPtr;
        rif.status[`DTS_STAT_RDPTR] = rdPtr;
        rif.status[`DTS_STAT_FILL] = fill;
        rif.status[`DTS_STAT_ERR] = errs;
    end

    // ------------------------------------------------------------
    // read latency path
    // ------------------------------------------------------------
    dts_pkg::dts_slot_t slotIn;
    dts_pkg::dts_slot_t slotOut;
    logic [5:0] latEff;
    logic [`DTS_TAP_W-1:0] tapSel;
    logic [`DTS_BURST_W-1:0] calPat;

    // entries beyond the written count are flagged undefined
    assign slotIn = '{valid: execRd || execCal, isCal: execCal,
        undef: execRd && (rdPtr >= fill), idx: rdPtr};

    // same latency as an ordinary burst-16 read, clamped to the pipe
    always_comb begin
        latEff = rif.readLat;
        if (latEff < `DTS_LAT_MIN) begin
            latEff = `DTS_LAT_MIN;
        end
        if (latEff > `DTS_LAT_MAX) begin
            latEff = `DTS_LAT_MAX;
        end
        tapSel = 5'(latEff - `DTS_LAT_MIN);
    end

    dts_lat_pipe #(
        .W(6),
        .D(`DTS_PIPE_D)
    ) u_pipe (
        .clk(clk_sys),
        .rstN(rstN),
        .inData(slotIn),
        .tapSel(tapSel),
        .tapData(slotOut)
    );

    // calibration pattern: beat b carries pattern bit b on every dq
    always_comb begin
        calPat = '0;
        for (int b = 0; b < `DTS_BEATS; b++) begin
            calPat[b*`DTS_DQ +: `DTS_DQ] = {`DTS_DQ{rif.pattern[b]}};
        end
    end

    // output burst and dmi drive
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdBurst <= '0;
            rdBurstValid <= 1'b0;
            dmiDrive <= 1'b0;
            rdUndef <= 1'b0;
        end else begin
            rdBurstValid <= slotOut.valid;
            rdBurst <= !slotOut.valid ? '0 : (slotOut.isCal ? calPat : fifoMem[slotOut.idx]);
            dmiDrive <= slotOut.valid && (slotOut.isCal || rif.dmEn || rif.wdbiEn || rif.rdbiEn);
            rdUndef <= slotOut.valid && slotOut.undef;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    chk_rdptr_range: assert property (rdPtr < `DTS_FIFO_DEPTH && wrPtr < `DTS_FIFO_DEPTH)
        else $error("fifo pointer out of range");

    chk_rdptr_step: assert property (execRd && !disturb |=>
        rdPtr == (($past(rdPtr) == `DTS_PTR_LAST) ? 3'h0 : $past(rdPtr) + 3'h1))
        else $error("read pointer did not advance or wrap");

    chk_wrptr_over: assert property (wrTake && wrPtr == `DTS_PTR_LAST |=>
        wrPtr == 3'h0 && fill == `DTS_FIFO_DEPTH)
        else $error("sixth burst does not overwrite the first entry");

    chk_disturb_clear: assert property (disturb |=> rdPtr == 3'h0 && wrPtr == 3'h0 && fill == 3'h0)
        else $error("pointers not reset after a disturbing access");

    chk_wrfifo_take: assert property (ckeS && wrBurstValid && wrArm != 3'h0 && !disturb
        && fill != `DTS_FIFO_DEPTH |=> fill == $past(fill) + 3'h1)
        else $error("write-fifo burst not accepted");

    chk_rd_latency: assert property (execRd |-> ##[2:33] rdBurstValid)
        else $error("read-fifo data not returned within read latency");

    chk_seamless_rd: assert property ((execRd && !disturb) ##8 (execRd && !disturb)
        |=> rdPtr != $past(rdPtr, 9))
        else $error("back-to-back read-fifo commands lost one");

    chk_dmi_drive: assert property (rdBurstValid && (rif.dmEn || rif.wdbiEn || rif.rdbiEn)
        && $stable(rif.dmEn) && $stable(rif.wdbiEn) && $stable(rif.rdbiEn) |-> dmiDrive)
        else $error("dmi not driven during read-fifo output");

    chk_undef_flag: assert property (execRd && rdPtr >= fill
        |-> ##[2:33] (rdBurstValid && rdUndef))
        else $error("unwritten entry not flagged undefined");

    cov_rd_wrap: cover property (execRd && rdPtr == `DTS_PTR_LAST);
    cov_wr_over: cover property (wrTake && fill == `DTS_FIFO_DEPTH);
    cov_cal_out: cover property (execCal ##[2:33] (rdBurstValid && dmiDrive));
    cov_gap_err: cover property (errSet[2]);
endmodule

// [tb/dts_ctrl_model.sv]
// controller-side model driving the command link and the write-fifo data
`timescale 1ns/1ps
module dts_ctrl_model (
    input wire logic clk,
    output logic [3:0] cmdOp,
    output logic [5:0] casOperand,
    output logic cke,
    output logic [127:0] wrBurst,
    output logic wrBurstValid
);
    // idle link at time zero, clock enabled
    initial begin
        cmdOp = 4'h0;
        casOperand = 6'h00;
        cke = 1'b1;
        wrBurst = {128{1'b0}};
        wrBurstValid = 1'b0;
    end

    // training command, then cas-2 in the very next cycle unless a fault is commanded
    task automatic train(input dts_pkg::dts_cmd_t op, input logic [5:0] casOp, input logic withCas);
        @(posedge clk);
        cmdOp <= op;
        @(posedge clk);
        cmdOp <= withCas ? 4'(dts_pkg::CMD_CAS2) : 4'(dts_pkg::CMD_NONE);
        casOperand <= casOp;
        @(posedge clk);
        cmdOp <= 4'(dts_pkg::CMD_NONE);
        casOperand <= 6'h00;
    endtask

    // plain single-cycle command
    task automatic plain(input dts_pkg::dts_cmd_t op);
        @(posedge clk);
        cmdOp <= op;
        @(posedge clk);
        cmdOp <= 4'(dts_pkg::CMD_NONE);
    endtask

    // one write-fifo burst; the released bus shows the inverse afterwards
    task automatic burst(input logic [127:0] data);
        @(posedge clk);
        wrBurst <= data;
        wrBurstValid <= 1'b1;
        @(posedge clk);
        wrBurst <= ~data;
        wrBurstValid <= 1'b0;
    endtask

    // spacing held by the controller between commands
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask

    // clock enable dropped for a few cycles, then resynchronised
    task automatic cke_low(input int n);
        @(posedge clk);
        cke <= 1'b0;
        repeat (n) @(posedge clk);
        cke <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// [tb/dts_top_tb.sv]
// testbench for the training fifo sequencer
`timescale 1ns/1ps
`include "dts_cfg.svh"
module dts_top_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] cmdOp;
    logic [5:0] casOperand;
    logic cke, wrBurstValid, rdBurstValid, dmiDrive, rdUndef;
    logic [127:0] wrBurst, rdBurst;
    int badCount = 0;
    int testsRun = 0;

    always #4 clk_sys = ~clk_sys;
    assign hready = hreadyout;

    dts_top i_dts_top (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmdOp(cmdOp), .casOperand(casOperand), .cke(cke),
        .wrBurst(wrBurst), .wrBurstValid(wrBurstValid), .rdBurst(rdBurst), .rdBurstValid(rdBurstValid),
        .dmiDrive(dmiDrive), .rdUndef(rdUndef));
    dts_ctrl_model i_dts_ctrl_model (.clk(clk_sys), .cmdOp(cmdOp), .casOperand(casOperand), .cke(cke),
        .wrBurst(wrBurst), .wrBurstValid(wrBurstValid));

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", badCount, testsRun);
        if (badCount == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chkbits(input logic [127:0] got, input logic [127:0] exp, input string msg);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // ahb-lite master
    // ----------------------------------------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                chk32(32'h0, 32'h1, "bus ready timeout");
                end_sim();
            end
            @(posedge clk_sys);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdat);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wr ? wdat : 32'h0;
        wait_rdy();
        rd = hrdata;
        chk32({31'h0, hresp}, 32'h0, "bus response not okay");
        hsel <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // expected values
    // ----------------------------------------------------------------
    function automatic logic [127:0] dat(input int i);
        return {4{32'hC0DE0000 + 32'(i)}};
    endfunction

    function automatic logic [31:0] stat(input int wp, input int rp, input int fl, input int er);
        logic [31:0] s;
        s = 32'h0;
        s[`DTS_STAT_WRPTR] = 3'(wp);
        s[`DTS_STAT_RDPTR] = 3'(rp);
        s[`DTS_STAT_FILL] = 3'(fl);
        s[`DTS_STAT_ERR] = 3'(er);
        return s;
    endfunction

    // read-type training command, then the burst exactly readLat cycles after cas-2
    task automatic rd_check(input dts_pkg::dts_cmd_t op, input logic [127:0] exp, input logic undef,
        input logic dmi);
        i_dts_ctrl_model.train(op, 6'h00, 1'b1);
        repeat (int'(`DTS_LAT_RST) - 2) @(posedge clk_sys);
        #1;
        chkbits({127'h0, rdBurstValid}, 128'h0, "burst early");
        @(posedge clk_sys);
        #1;
        chkbits({125'h0, rdBurstValid, dmiDrive, rdUndef}, {125'h0, 1'b1, dmi, undef}, "burst flags");
        if (!undef) begin
            chkbits(rdBurst, exp, "burst data");
        end
        @(posedge clk_sys);
        #1;
        chkbits({127'h0, rdBurstValid}, 128'h0, "burst longer than one cycle");
    endtask

    task automatic wr_fifo(input logic [127:0] d);
        i_dts_ctrl_model.train(dts_pkg::CMD_WRFIFO, 6'h00, 1'b1);
        i_dts_ctrl_model.burst(d);
        i_dts_ctrl_model.pause(3);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [127:0] cal;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        // register reset values and an unmapped place
        ahb(1'b0, `DTS_OFS_CTRL, 32'h0);
        chk32(rd, 32'(`DTS_LAT_RST), "ctrl reset");
        ahb(1'b0, `DTS_OFS_GAP, 32'h0);
        chk32(rd, 32'(`DTS_GAP_RST), "gap reset");
        ahb(1'b0, 8'h10, 32'h0);
        chk32(rd, 32'h0, "unmapped read");
        ahb(1'b1, `DTS_OFS_PAT, 32'h0000A5C3);
        // five write-fifo bursts at tCCD, then six reads with wrap
        for (int i = 0; i < 5; i++) wr_fifo(dat(i));
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(0, 0, 5, 0), "fifo full");
        i_dts_ctrl_model.pause(16);
        for (int i = 0; i < 6; i++) rd_check(dts_pkg::CMD_RDFIFO, dat(i % 5), 1'b0, 1'b0);
        // two read-fifo commands one tCCD apart return both bursts seamlessly
        i_dts_ctrl_model.train(dts_pkg::CMD_RDFIFO, 6'h00, 1'b1);
        i_dts_ctrl_model.pause(5);
        i_dts_ctrl_model.train(dts_pkg::CMD_RDFIFO, 6'h00, 1'b1);
        repeat (int'(`DTS_LAT_RST) - 9) @(posedge clk_sys);
        #1;
        chkbits(rdBurstValid ? rdBurst : 128'h0, dat(1), "seamless first burst");
        repeat (8) @(posedge clk_sys);
        #1;
        chkbits(rdBurstValid ? rdBurst : 128'h0, dat(2), "seamless second burst");
        // a read too soon after read-fifo is flagged and disturbs the pointers
        i_dts_ctrl_model.plain(dts_pkg::CMD_RD);
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(0, 0, 0, 4), "read gap error");
        ahb(1'b1, `DTS_OFS_STAT, 32'h00040000);
        ahb(1'b0, 8'h10, 32'h0);
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(0, 0, 0, 0), "error cleared");
        // sixth write overwrites entry zero; mask enable drives dmi
        for (int i = 0; i < 6; i++) wr_fifo(dat(10 + i));
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(1, 0, 5, 0), "six writes");
        rd_check(dts_pkg::CMD_RDFIFO, dat(15), 1'b0, 1'b0);
        ahb(1'b1, `DTS_OFS_CTRL, 32'(`DTS_LAT_RST) | 32'h100);
        rd_check(dts_pkg::CMD_RDFIFO, dat(11), 1'b0, 1'b1);
        ahb(1'b1, `DTS_OFS_CTRL, 32'(`DTS_LAT_RST) | 32'h600);
        rd_check(dts_pkg::CMD_RDFIFO, dat(12), 1'b0, 1'b1);
        // clock enable low disturbs, then a short fill leaves entries undefined
        i_dts_ctrl_model.cke_low(3);
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(0, 0, 0, 0), "cke disturb");
        ahb(1'b1, `DTS_OFS_CTRL, 32'(`DTS_LAT_RST));
        wr_fifo(dat(20));
        wr_fifo(dat(21));
        for (int i = 0; i < 3; i++) rd_check(dts_pkg::CMD_RDFIFO, dat(20 + i), i == 2, 1'b0);
        // calibration pattern, then operand and missing cas-2 faults
        for (int b = 0; b < 16; b++) cal[b*8+:8] = {8{16'hA5C3 >> b & 16'h1 ? 1'b1 : 1'b0}};
        rd_check(dts_pkg::CMD_RDCAL, cal, 1'b0, 1'b1);
        i_dts_ctrl_model.train(dts_pkg::CMD_WRFIFO, 6'h00, 1'b0);
        i_dts_ctrl_model.train(dts_pkg::CMD_RDCAL, 6'h15, 1'b1);
        i_dts_ctrl_model.pause(40);
        ahb(1'b0, `DTS_OFS_STAT, 32'h0);
        chk32(rd, stat(0, 0, 0, 3), "operand and cas-2 errors");
        end_sim();
    end

    // overall limit on the run
    initial begin
        repeat (20000) @(posedge clk_sys);
        chk32(32'h0, 32'h1, "run timeout");
        end_sim();
    end
endmodule
